// file: common/drive_word_pkg.sv
// Package for the drive parameter and control word decoder.
// Assumes a single 100 MHz clock and AHB-Lite register access.
package drive_word_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MSG_IDENT = 8'h04;
   localparam logic [7:0] OFS_MSG_INDEX = 8'h08;
   localparam logic [7:0] OFS_MSG_VALUE = 8'h0c;
   localparam logic [7:0] OFS_MSG_PROC = 8'h10;
   localparam logic [7:0] OFS_MSG_LEN = 8'h14;
   localparam logic [7:0] OFS_COMMIT = 8'h18;
   localparam logic [7:0] OFS_REPLY_VALUE = 8'h1c;
   localparam logic [7:0] OFS_REPLY_PROC = 8'h20;
   localparam logic [7:0] OFS_CMD_STATUS = 8'h24;
   localparam logic [7:0] OFS_PARAM_DATA = 8'h28;
   localparam logic [7:0] OFS_PARAM_TYPE = 8'h2c;
   localparam logic [7:0] OFS_FAULT_CODE = 8'h30;
   // Reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // Field positions in the control register
   localparam int CTRL_NATIVE_BIT = 0;
   // Native message profile value
   localparam logic [7:0] PROFILE_NATIVE = 8'h01;
   // Control word bit positions
   localparam int CW_PRESET_LO = 0;
   localparam int CW_PRESET_HI = 1;
   localparam int CW_DC_BRAKE = 2;
   localparam int CW_COAST = 3;
   localparam int CW_QSTOP = 4;
   localparam int CW_FREEZE = 5;
   localparam int CW_START = 6;
   localparam int CW_RESET = 7;
   localparam int CW_JOG = 8;
   localparam int CW_RAMP2 = 9;
   localparam int CW_VALID = 10;
   // Parameter command codes
   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_READ = 4'h1;
   localparam logic [3:0] CMD_WR_WORD = 4'h2;
   localparam logic [3:0] CMD_WR_DWORD = 4'h3;
   localparam logic [3:0] CMD_WR_EE_DWORD = 4'hd;
   localparam logic [3:0] CMD_WR_EE_WORD = 4'he;
   localparam logic [3:0] CMD_TEXT = 4'hf;
   // Reply codes
   localparam logic [3:0] RSP_WORD = 4'h1;
   localparam logic [3:0] RSP_DWORD = 4'h2;
   localparam logic [3:0] RSP_FAIL = 4'h7;
   localparam logic [3:0] RSP_TEXT = 4'hf;
   // Data type codes
   localparam logic [3:0] DT_INT16 = 4'h3;
   localparam logic [3:0] DT_INT32 = 4'h4;
   localparam logic [3:0] DT_UINT8 = 4'h5;
   localparam logic [3:0] DT_UINT16 = 4'h6;
   localparam logic [3:0] DT_UINT32 = 4'h7;
   localparam logic [3:0] DT_TEXT = 4'h9;
   // Conversion indices
   localparam logic signed [7:0] CONV_X100 = 8'sh02;
   localparam logic signed [7:0] CONV_X10 = 8'sh01;
   localparam logic signed [7:0] CONV_X1 = 8'sh00;
   localparam logic signed [7:0] CONV_MIN = -8'sd5;
   localparam logic signed [7:0] CONV_TENTH = 8'sh49;
   // Fault report values
   localparam logic [31:0] FAULT_TYPE = 32'h0000_0005;
   localparam logic [31:0] FAULT_NOPARAM = 32'h0000_0000;
   // Fault code range for error log entries
   localparam logic [7:0] FAULT_CODE_MIN = 8'h01;
   localparam logic [7:0] FAULT_CODE_MAX = 8'h63;
   // AHB transfer type
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : drive_word_pkg

// file: logic/drive_word_decoder.sv
// Decoder for the parameter and process block of a drive control message.
// Assumes a framing block has already checked the message and writes its
// fields here over AHB-Lite, then commits it with one write.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module drive_word_decoder
   import drive_word_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Drive inputs
   input wire logic [7:0] msg_profile,
   input wire logic [15:0] status_word,
   input wire logic [15:0] out_freq,
   input wire logic [7:0] fault_log_code,
   // Decoded commands
   output logic [1:0] preset_sel,
   output logic dc_brake,
   output logic coast,
   output logic quick_stop,
   output logic freeze,
   output logic ramp_stop,
   output logic start_ok,
   output logic trip_reset,
   output logic jog,
   output logic ramp2,
   output logic [15:0] reference
);

   // Bus phase capture
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] addr_ff;
   logic [31:0] msg_ident_ff;
   logic [31:0] msg_index_ff;
   logic [31:0] msg_value_ff;
   logic [31:0] msg_proc_ff;
   logic [7:0] msg_len_ff;
   logic [31:0] param_data_ff;
   logic [7:0] param_type_ff;
   logic [31:0] reply_value_ff;
   logic [31:0] reply_proc_ff;
   logic [3:0] reply_code_ff;
   logic text_write_ff;
   logic [7:0] text_len_ff;
   logic [15:0] cw_ff;
   logic cw_bit7_prev_ff;
   logic trip_reset_ff;
   logic ctrl_native_ff;
   logic commit_stb;
   logic addr_ok;

   assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase capture
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok && hwrite && hsize == 3'h2;
         rd_pend_ff <= addr_ok && !hwrite;
         if (addr_ok) begin
            addr_ff <= haddr;
         end
      end
   end

   assign commit_stb = wr_pend_ff && addr_ff == OFS_COMMIT;

   // Message field registers written by software, four-byte value
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_native_ff <= RST_CTRL[CTRL_NATIVE_BIT];
         msg_ident_ff <= RST_ZERO;
         msg_index_ff <= RST_ZERO;
         msg_value_ff <= RST_ZERO;
         msg_proc_ff <= RST_ZERO;
         msg_len_ff <= RST_ZERO[7:0];
         param_data_ff <= RST_ZERO;
         param_type_ff <= RST_ZERO[7:0];
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            OFS_CTRL: ctrl_native_ff <= hwdata[CTRL_NATIVE_BIT];
            OFS_MSG_IDENT: msg_ident_ff <= hwdata;
            OFS_MSG_INDEX: msg_index_ff <= hwdata;
            OFS_MSG_VALUE: msg_value_ff <= hwdata;
            OFS_MSG_PROC: msg_proc_ff <= hwdata;
            OFS_MSG_LEN: msg_len_ff <= hwdata[7:0];
            OFS_PARAM_DATA: param_data_ff <= hwdata;
            OFS_PARAM_TYPE: param_type_ff <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Parameter command handling on commit
   logic [3:0] cmd;
   logic [3:0] dtype;
   logic type_ok;
   assign cmd = msg_ident_ff[15:12];
   assign dtype = param_type_ff[3:0];
   // Supported types only
   assign type_ok = dtype inside {DT_INT16, DT_INT32, DT_UINT8, DT_UINT16, DT_UINT32, DT_TEXT};

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reply_value_ff <= RST_ZERO;
         reply_code_ff <= CMD_NONE;
         text_write_ff <= 1'b0;
         text_len_ff <= 8'h00;
      end else if (commit_stb) begin
         // Value passes as raw integer; scaling is by conversion index
         if (!type_ok) begin
            reply_code_ff <= RSP_FAIL;
            reply_value_ff <= FAULT_TYPE;
         end else if (cmd == CMD_TEXT) begin
            // Text op direction from index, length from length field
            reply_code_ff <= RSP_TEXT;
            text_write_ff <= msg_index_ff[8];
            text_len_ff <= msg_len_ff;
            reply_value_ff <= param_data_ff;
         end else if (cmd == CMD_READ) begin
            // Current value returned, incoming value ignored
            if (msg_index_ff[7:0] != 8'h00) begin
               // Error log entry, clamp to fault code range
               reply_value_ff <= {24'h0, (fault_log_code < FAULT_CODE_MIN) ? FAULT_CODE_MIN :
                  (fault_log_code > FAULT_CODE_MAX) ? FAULT_CODE_MAX : fault_log_code};
            end else begin
               reply_value_ff <= param_data_ff;
            end
            reply_code_ff <= (dtype == DT_INT32 || dtype == DT_UINT32) ? RSP_DWORD : RSP_WORD;
         end else if (cmd inside {CMD_WR_WORD, CMD_WR_DWORD, CMD_WR_EE_DWORD, CMD_WR_EE_WORD}) begin
            // New value taken from the message
            reply_value_ff <= msg_value_ff;
            reply_code_ff <= (cmd == CMD_WR_WORD || cmd == CMD_WR_EE_WORD) ? RSP_WORD : RSP_DWORD;
         end else begin
            reply_code_ff <= CMD_NONE;
            reply_value_ff <= FAULT_NOPARAM;
         end
      end
   end

   // Reply process words: status then frequency
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reply_proc_ff <= RST_ZERO;
      end else if (commit_stb) begin
         reply_proc_ff <= {status_word, out_freq};
      end
   end

   // Control word latch: native profile, valid bit, commit only
   logic cw_take;
   assign cw_take = commit_stb && msg_profile == PROFILE_NATIVE && msg_proc_ff[16 + CW_VALID];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cw_ff <= 16'h0000;
      end else if (cw_take) begin
         cw_ff <= msg_proc_ff[31:16];
      end
   end

   // Reference word follows control word
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reference <= 16'h0000;
      end else if (cw_take) begin
         reference <= msg_proc_ff[15:0];
      end
   end

   // Trip reset on 0 to 1 of bit 7 only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cw_bit7_prev_ff <= 1'b0;
         trip_reset_ff <= 1'b0;
      end else begin
         trip_reset_ff <= 1'b0;
         if (cw_take) begin
            cw_bit7_prev_ff <= msg_proc_ff[16 + CW_RESET];
            trip_reset_ff <= msg_proc_ff[16 + CW_RESET] && !cw_bit7_prev_ff;
         end
      end
   end
   assign trip_reset = trip_reset_ff;

   // Decoded commands, outputs from control word register
   assign preset_sel = cw_ff[CW_PRESET_HI:CW_PRESET_LO];
   assign dc_brake = !cw_ff[CW_DC_BRAKE];
   assign coast = !cw_ff[CW_COAST];
   // Quick stop is a stop too, so a frozen output ignores it
   assign quick_stop = !cw_ff[CW_QSTOP] && cw_ff[CW_FREEZE];
   assign freeze = !cw_ff[CW_FREEZE];
   // Freeze masks ramp stop; coast and brake still act
   assign ramp_stop = !cw_ff[CW_START] && cw_ff[CW_FREEZE];
   assign start_ok = cw_ff[CW_START] && cw_ff[CW_COAST];
   assign jog = cw_ff[CW_JOG];
   assign ramp2 = cw_ff[CW_RAMP2];

   // Read data
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_pend_ff) begin
         unique case (addr_ff)
            OFS_CTRL: hrdata = {31'h0, ctrl_native_ff};
            OFS_MSG_IDENT: hrdata = msg_ident_ff;
            OFS_MSG_INDEX: hrdata = msg_index_ff;
            OFS_MSG_VALUE: hrdata = msg_value_ff;
            OFS_MSG_PROC: hrdata = msg_proc_ff;
            OFS_MSG_LEN: hrdata = {24'h0, msg_len_ff};
            OFS_REPLY_VALUE: hrdata = reply_value_ff;
            OFS_REPLY_PROC: hrdata = reply_proc_ff;
            OFS_CMD_STATUS: hrdata = {15'h0, text_write_ff, text_len_ff, 4'h0, reply_code_ff};
            OFS_PARAM_DATA: hrdata = param_data_ff;
            OFS_PARAM_TYPE: hrdata = {24'h0, param_type_ff};
            OFS_FAULT_CODE: hrdata = {16'h0, cw_ff};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Assertions
   a_ignore_invalid: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && !msg_proc_ff[16 + CW_VALID] |=> $stable(cw_ff))
      else $error("control word changed though invalid");
   a_profile_gate: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && msg_profile != PROFILE_NATIVE |=> $stable(cw_ff))
      else $error("control word changed in other profile");
   a_no_partial: assert property (@(posedge mclk) disable iff (!rstn)
      !commit_stb |=> $stable(cw_ff))
      else $error("control word changed without commit");
   a_reset_edge: assert property (@(posedge mclk) disable iff (!rstn)
      trip_reset |=> !trip_reset)
      else $error("trip reset longer than one cycle");
   a_reset_cause: assert property (@(posedge mclk) disable iff (!rstn)
      trip_reset |-> cw_ff[CW_RESET] && !$past(cw_ff[CW_RESET]))
      else $error("trip reset without rising bit");
   a_fault_range: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && type_ok && cmd == CMD_READ && msg_index_ff[7:0] != 8'h00
      |=> reply_value_ff >= 32'd1 && reply_value_ff <= 32'd99)
      else $error("fault code out of range");
   a_read_value: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && type_ok && cmd == CMD_READ && msg_index_ff[7:0] == 8'h00
      |=> reply_value_ff == $past(param_data_ff))
      else $error("read reply not current value");
   a_bad_type: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && !type_ok |=> reply_code_ff == RSP_FAIL)
      else $error("unsupported type accepted");
   a_text_len: assert property (@(posedge mclk) disable iff (!rstn)
      commit_stb && type_ok && cmd == CMD_TEXT |=> text_len_ff == $past(msg_len_ff))
      else $error("text length not taken");
   a_freeze_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !cw_ff[CW_FREEZE] |-> !ramp_stop && !quick_stop)
      else $error("ramp stop while frozen");
   a_brake_dec: assert property (@(posedge mclk) disable iff (!rstn)
      dc_brake == !cw_ff[CW_DC_BRAKE] && coast == !cw_ff[CW_COAST])
      else $error("brake or coast decode wrong");
endmodule : drive_word_decoder

// file: tb/ahb_master.sv
// Bus master model: single whole-word AHB-Lite transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module ahb_master
   import drive_word_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Address and data phase
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Slave answer
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // One transfer, address phase driven right after the next rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask : xfer
endmodule : ahb_master

// file: tb/tb.sv
// Bench for the drive word decoder: control decode, replies, bus.
// Assumes the bus master model and the shared package.
`timescale 1ns/1ps
module tb
   import drive_word_pkg::*;
;
   // Bench signals
   logic mclk, rstn, hsel, hwrite, hreadyout, hresp;
   logic [7:0] haddr, msg_profile, fault_log_code;
   logic [1:0] htrans, preset_sel;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, q;
   logic [15:0] status_word, out_freq, reference, last_ref;
   logic dc_brake, coast, quick_stop, freeze, ramp_stop, start_ok, trip_reset, jog, ramp2;
   logic [9:0] last_cmd, cmd_now;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   // Parameter command table: command, type, reply code
   logic [3:0] pc [13] = '{CMD_READ, CMD_READ, CMD_READ, CMD_READ, CMD_READ, CMD_READ, CMD_WR_WORD,
      CMD_WR_DWORD, CMD_WR_EE_DWORD, CMD_WR_EE_WORD, CMD_NONE, CMD_TEXT, CMD_TEXT};
   logic [3:0] pt [13] = '{DT_INT16, DT_INT32, DT_UINT8, DT_UINT16, DT_UINT32, 4'h8, DT_UINT16,
      DT_UINT32, DT_INT32, DT_INT16, DT_UINT16, DT_TEXT, DT_TEXT};
   logic [3:0] pr [13] = '{RSP_WORD, RSP_DWORD, RSP_WORD, RSP_WORD, RSP_DWORD, RSP_FAIL, RSP_WORD,
      RSP_DWORD, RSP_DWORD, RSP_WORD, 4'h0, RSP_TEXT, RSP_TEXT};

   // Decoded outputs gathered for comparison
   assign cmd_now = {preset_sel, dc_brake, coast, quick_stop, freeze, ramp_stop, start_ok, jog, ramp2};

   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Design and bus master
   drive_word_decoder drive_word_decoder_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .msg_profile(msg_profile),
      .status_word(status_word), .out_freq(out_freq), .fault_log_code(fault_log_code),
      .preset_sel(preset_sel), .dc_brake(dc_brake), .coast(coast), .quick_stop(quick_stop),
      .freeze(freeze), .ramp_stop(ramp_stop), .start_ok(start_ok), .trip_reset(trip_reset),
      .jog(jog), .ramp2(ramp2), .reference(reference));
   ahb_master master_i (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Expected command outputs of an accepted control word
   function automatic logic [9:0] cmd_of(input logic [15:0] w);
      return {w[1:0], ~w[2], ~w[3], ~w[4] & w[5], ~w[5], ~w[6] & w[5], w[6] & w[3], w[8], w[9]};
   endfunction : cmd_of

   // Writes one message and commits it
   task automatic send(input logic [31:0] id, ix, v, p, input logic [7:0] len);
      master_i.xfer(1'b1, OFS_MSG_IDENT, id, q);
      master_i.xfer(1'b1, OFS_MSG_INDEX, ix, q);
      master_i.xfer(1'b1, OFS_MSG_VALUE, v, q);
      master_i.xfer(1'b1, OFS_MSG_PROC, p, q);
      master_i.xfer(1'b1, OFS_MSG_LEN, {24'h0, len}, q);
      master_i.xfer(1'b1, OFS_COMMIT, 32'h1, q);
      #1;
   endtask : send

   task automatic ctl(input logic [15:0] w, r, input logic acc);
      send({16'h0, CMD_NONE, 12'h0}, 32'h0, 32'h0, {w, r}, 8'h06);
      if (acc) begin
         last_cmd = cmd_of(w);
         last_ref = r;
      end
   endtask : ctl

   task automatic see();
      chk("commands", {22'h0, last_cmd}, {22'h0, cmd_now});
      chk("reference", {16'h0, last_ref}, {16'h0, reference});
   endtask : see

   task automatic t_reset();
      last_cmd = 10'b0011010000;
      last_ref = 16'h0;
      see();
      master_i.xfer(1'b0, OFS_CTRL, 32'h0, q);
      chk("ctrl_reset", RST_CTRL, q);
      master_i.xfer(1'b1, OFS_CTRL, 32'h1, q);
      master_i.xfer(1'b0, OFS_CTRL, 32'h0, q);
      chk("ctrl_rw", 32'h1, q);
      master_i.xfer(1'b0, 8'h3c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
   endtask : t_reset

   task automatic t_decode();
      logic [15:0] cw [9] = '{16'h047c, 16'h047d, 16'h047e, 16'h047f, 16'h0400, 16'h0420, 16'h057c, 16'h067c,
         16'h0440};
      for (int i = 0; i < 9; i++) begin
         ctl(cw[i], {4{i[3:0]}}, 1'b1);
         see();
      end
   endtask : t_decode

   task automatic t_ignore();
      master_i.xfer(1'b1, OFS_MSG_PROC, 32'h047f_5555, q);
      #1;
      see();
      ctl(16'h0383, 16'hbeef, 1'b0);
      see();
      msg_profile <= 8'h02;
      ctl(16'h047d, 16'h1234, 1'b0);
      see();
      msg_profile <= PROFILE_NATIVE;
   endtask : t_ignore

   task automatic t_trip();
      ctl(16'h04fc, 16'h0, 1'b1);
      chk("trip_rise", 32'h1, {31'h0, trip_reset});
      @(posedge mclk);
      #1;
      chk("trip_pulse", 32'h0, {31'h0, trip_reset});
      ctl(16'h04fc, 16'h0, 1'b1);
      chk("trip_level", 32'h0, {31'h0, trip_reset});
   endtask : t_trip

   task automatic t_param();
      logic [31:0] v;
      for (int i = 0; i < 13; i++) begin
         v = {28'h8a5c010, i[3:0]};
         master_i.xfer(1'b1, OFS_PARAM_DATA, v, q);
         master_i.xfer(1'b1, OFS_PARAM_TYPE, {28'h0, pt[i]}, q);
         send({16'h0, pc[i], 12'h0cf}, {23'h0, i == 12, 8'h0}, (pc[i] == CMD_READ) ? 32'h0 : v, 32'h0, 8'h0e);
         master_i.xfer(1'b0, OFS_CMD_STATUS, 32'h0, q);
         chk("reply_code", {28'h0, pr[i]}, {28'h0, q[3:0]});
         if (i > 10) chk("text_status", {15'h0, i == 12, 16'h0e00}, {15'h0, q[16:8], 8'h0});
         master_i.xfer(1'b0, OFS_REPLY_VALUE, 32'h0, q);
         if (i < 5) chk("reply_value", v, q);
         if (i == 5) chk("fault_report", FAULT_TYPE, q);
         if (i > 5 && i < 10) chk("write_value", v, q);
         if (i == 10) chk("no_cmd_value", FAULT_NOPARAM, q);
      end
   endtask : t_param

   task automatic t_fault();
      logic [7:0] c [3] = '{8'h00, 8'h2a, 8'hc8};
      logic [7:0] e [3] = '{FAULT_CODE_MIN, 8'h2a, FAULT_CODE_MAX};
      for (int i = 0; i < 3; i++) begin
         fault_log_code <= c[i];
         master_i.xfer(1'b1, OFS_PARAM_TYPE, {28'h0, DT_UINT8}, q);
         send({16'h0, CMD_READ, 12'h267}, 32'h1, 32'h0, 32'h0, 8'h06);
         master_i.xfer(1'b0, OFS_REPLY_VALUE, 32'h0, q);
         chk("fault_code", {24'h0, e[i]}, q);
      end
   endtask : t_fault

   task automatic t_proc();
      status_word <= 16'ha5c3;
      out_freq <= 16'h1e2f;
      ctl(16'h047c, 16'h2468, 1'b1);
      see();
      master_i.xfer(1'b0, OFS_REPLY_PROC, 32'h0, q);
      chk("reply_proc", 32'ha5c3_1e2f, q);
   endtask : t_proc

   task automatic print_verdict();
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      msg_profile = PROFILE_NATIVE;
      status_word = 16'h0;
      out_freq = 16'h0;
      fault_log_code = 8'h0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_decode();
      t_ignore();
      t_trip();
      t_param();
      t_fault();
      t_proc();
      print_verdict();
   end
endmodule : tb
